/* hdl/smf_defs.svh */
// Register map, field positions, reset values and sizes of the switch mode block.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef SMF_DEFS_SVH
`define SMF_DEFS_SVH

// Register offsets
`define SMF_ADDR_W 8
`define SMF_OFS_CTRL 8'h00
`define SMF_OFS_MODE 8'h01
`define SMF_OFS_RESULT 8'h02
`define SMF_OFS_IRQ_STAT 8'h08
`define SMF_OFS_IRQ_MASK 8'h09

// Control register fields
`define SMF_CTRL_W 6
`define SMF_CTRL_ARM 5
`define SMF_CTRL_RST 6'h00

// Interface mode register fields
`define SMF_MODE_W 10
`define SMF_MODE_VAL_HI 9
`define SMF_MODE_VAL_LO 5
`define SMF_MODE_GO 4
`define SMF_MODE_STBY 3
`define SMF_MODE_START 2
`define SMF_MODE_RATE_HI 1
`define SMF_MODE_RATE_LO 0
`define SMF_MODE_RST 10'h000

// Result register fields
`define SMF_RES_DONE 12
`define SMF_RES_PHASE 11
`define SMF_OFF_W 11
`define SMF_OFF_MAX 11'h7ff
`define SMF_OFF_ZERO 11'h000

// Interrupt bits
`define SMF_IRQ_W 2
`define SMF_IRQ_FILL 0
`define SMF_IRQ_EVAL 1
`define SMF_IRQ_RST 2'h0

// Connection memory and fill
`define SMF_CM_AW 11
`define SMF_CM_LAST 11'h7ff
`define SMF_CM_ZERO 11'h000
`define SMF_CM_LOW_ZERO 11'h000
`define SMF_FILL_FRAMES 2'h2
`define SMF_FRAMES_ZERO 2'h0
`define SMF_STREAMS 16

// Rate codes
`define SMF_RATE_2M 2'h0
`define SMF_RATE_4M 2'h1
`define SMF_RATE_8M 2'h2
`define SMF_RATE_RSVD 2'h3

`define SMF_DATA_ZERO 16'h0000

`endif

/* hdl/smf_pkg.sv */
// Types shared by the switch mode block: state encodings and state records.
// Assumes smf_defs.svh is on the include path.
`include "smf_defs.svh"

package smf_pkg;

	// Offset measurement sequence, Gray coded along idle, armed, counting, done
	typedef enum logic [1:0] {
		SMF_EV_IDLE = 2'h0,
		SMF_EV_ARMED = 2'h1,
		SMF_EV_COUNT = 2'h3,
		SMF_EV_DONE = 2'h2
	} smf_ev_e;

	// Block fill sequence, Gray coded along idle, writing, waiting
	typedef enum logic [1:0] {
		SMF_FL_IDLE = 2'h0,
		SMF_FL_WRITE = 2'h1,
		SMF_FL_WAIT = 2'h3
	} smf_fl_e;

	typedef struct packed {
		smf_ev_e state;
		logic start_prev;
		logic fe_prev;
		logic [`SMF_OFF_W-1:0] cnt;
		logic done;
		logic phase;
		logic [`SMF_OFF_W-1:0] offset;
		logic done_pulse;
	} smf_ev_s;

	typedef struct packed {
		logic [`SMF_CTRL_W-1:0] ctrl;
		logic [`SMF_MODE_W-1:0] mode;
		logic [`SMF_IRQ_W-1:0] stat;
		logic [`SMF_IRQ_W-1:0] mask;
		logic [15:0] rdata;
		smf_fl_e fstate;
		logic [`SMF_CM_AW-1:0] faddr;
		logic [1:0] frames;
		logic cm_we;
		logic [`SMF_CM_AW-1:0] cm_addr;
		logic [15:0] cm_wdata;
	} smf_top_s;

endpackage : smf_pkg

/* hdl/smf_offset_meas.sv */
// Frame offset measurement: counts master clocks from frame start to the
// frame evaluation edge and holds the result until the start bit falls.
// Assumes all inputs synchronous to mclk_i; phase_i comes from pad logic.
`timescale 1ns/1ps
`default_nettype none
`include "smf_defs.svh"

module smf_offset_meas (
	// Clock, reset, enable
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Control and frame timing
	input wire logic start_i,
	input wire logic frame_pulse_i,
	input wire logic frame_eval_input_i,
	input wire logic gci_mode_i,
	input wire logic half_phase_i,
	// Result
	output logic done_o,
	output logic half_cycle_phase_o,
	output logic [`SMF_OFF_W-1:0] measured_offset_o,
	output logic done_pulse_o
);

	smf_pkg::smf_ev_s st_q;
	smf_pkg::smf_ev_s st_d;
	logic edge_seen;

	// Falling edge normally, rising edge in GCI mode
	assign edge_seen = gci_mode_i ? (frame_eval_input_i & ~st_q.fe_prev) :
		(~frame_eval_input_i & st_q.fe_prev);

	// Next state of the measurement
	always_comb begin
		st_d = st_q;
		st_d.start_prev = start_i;
		st_d.fe_prev = frame_eval_input_i;
		st_d.done_pulse = 1'b0;
		case (st_q.state)
			smf_pkg::SMF_EV_IDLE: begin
				if (start_i & ~st_q.start_prev) begin
					st_d.state = smf_pkg::SMF_EV_ARMED;
				end
			end
			smf_pkg::SMF_EV_ARMED: begin
				if (frame_pulse_i) begin
					st_d.state = smf_pkg::SMF_EV_COUNT;
					st_d.cnt = `SMF_OFF_ZERO;
				end
			end
			smf_pkg::SMF_EV_COUNT: begin
				if (edge_seen) begin
					st_d.state = smf_pkg::SMF_EV_DONE;
					st_d.offset = st_q.cnt;
					st_d.phase = half_phase_i;
					st_d.done = 1'b1;
					st_d.done_pulse = 1'b1;
				end else if (st_q.cnt != `SMF_OFF_MAX) begin
					// Saturate rather than wrap so a missing edge never fakes a small offset
					st_d.cnt = st_q.cnt + 11'h001;
				end
			end
			smf_pkg::SMF_EV_DONE: begin
				st_d.state = smf_pkg::SMF_EV_DONE;
			end
			default: begin
				st_d.state = smf_pkg::SMF_EV_IDLE;
			end
		endcase
		// Falling start bit clears the result from any state
		if (~start_i & st_q.start_prev) begin
			st_d.state = smf_pkg::SMF_EV_IDLE;
			st_d.done = 1'b0;
			st_d.offset = `SMF_OFF_ZERO;
			st_d.phase = 1'b0;
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= '0;
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end

	assign done_o = st_q.done;
	assign half_cycle_phase_o = st_q.phase;
	assign measured_offset_o = st_q.offset;
	assign done_pulse_o = st_q.done_pulse & ce_i;

endmodule : smf_offset_meas

`default_nettype wire

/* hdl/smf_top.sv */
// Switch mode and frame offset registers: control and interface mode
// registers, block fill engine, output standby, offset result, interrupts.
// Assumes a host port with one-cycle strobes and a frame pulse from the
// serial timing; the connection memory takes one write per cycle.
// Functional notes
// - Fill loads value high, clears low bits
// - Fill starts on rising go bit only
// - Fill completes over two frames
// - Device clears go bit when done
// - Zero to go or arm aborts
// - Outputs float when drive pin, standby low
// - Rising start bit begins offset measurement
// - Measurement stops once done flag sets
// - Rate field decodes three rates, one reserved
// - Done flag sets valid, clears on fall
// - Phase bit gives half-clock resolution
// - Offset field binary, cleared on fall
// - Fill possible only while arm bit set
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "smf_defs.svh"

module smf_top (
	// Clock, reset, enable
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Host register port
	input wire logic [`SMF_ADDR_W-1:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// Frame timing and evaluation pins
	input wire logic frame_pulse_i,
	input wire logic frame_eval_input_i,
	input wire logic gci_mode_i,
	input wire logic half_phase_i,
	input wire logic output_drive_pin_i,
	// Serial output drivers, enable low while driving
	output logic [`SMF_STREAMS-1:0] serial_out_streams_oe_n_o,
	// Connection memory write port
	output logic cm_we_o,
	output logic [`SMF_CM_AW-1:0] cm_addr_o,
	output logic [15:0] cm_wdata_o,
	// Control register fields for the memory datapath
	output logic [3:0] stream_sel_o,
	output logic mem_select_o,
	// Rate decode
	output logic [1:0] rate_select_o,
	output logic rate_reserved_o,
	output logic fill_busy_o,
	// Interrupt
	output logic irq_o
);

	smf_pkg::smf_top_s st_q;
	smf_pkg::smf_top_s st_d;
	logic ev_done;
	logic ev_phase;
	logic [`SMF_OFF_W-1:0] ev_offset;
	logic ev_done_pulse;
	logic wr_ctrl;
	logic wr_mode;
	logic wr_stat;
	logic wr_mask;
	logic go_rise;
	logic abort;
	logic fill_done;
	logic [15:0] result_word;
	logic [`SMF_IRQ_W-1:0] events;

	// Offset measurement runs from the live start bit
	smf_offset_meas u_meas (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.start_i(st_q.mode[`SMF_MODE_START]),
		.frame_pulse_i(frame_pulse_i),
		.frame_eval_input_i(frame_eval_input_i),
		.gci_mode_i(gci_mode_i),
		.half_phase_i(half_phase_i),
		.done_o(ev_done),
		.half_cycle_phase_o(ev_phase),
		.measured_offset_o(ev_offset),
		.done_pulse_o(ev_done_pulse)
	);

	// Write decode
	assign wr_ctrl = wr_i & (addr_i == `SMF_OFS_CTRL);
	assign wr_mode = wr_i & (addr_i == `SMF_OFS_MODE);
	assign wr_stat = wr_i & (addr_i == `SMF_OFS_IRQ_STAT);
	assign wr_mask = wr_i & (addr_i == `SMF_OFS_IRQ_MASK);

	// Fill start and abort, both seen at the write itself
	assign go_rise = wr_mode & wdata_i[`SMF_MODE_GO] & ~st_q.mode[`SMF_MODE_GO];
	assign abort = (wr_mode & ~wdata_i[`SMF_MODE_GO]) |
		(wr_ctrl & ~wdata_i[`SMF_CTRL_ARM]);

	// Completion: every location written and two frame starts seen
	assign fill_done = (st_q.fstate == smf_pkg::SMF_FL_WAIT) &
		(st_q.frames == `SMF_FILL_FRAMES);

	// Result word, unused upper bits read zero
	assign result_word = {3'h0, ev_done, ev_phase, ev_offset};

	assign events[`SMF_IRQ_FILL] = fill_done;
	assign events[`SMF_IRQ_EVAL] = ev_done_pulse;

	// Register, fill and interrupt next state
	always_comb begin
		st_d = st_q;
		st_d.cm_we = 1'b0;
		st_d.rdata = `SMF_DATA_ZERO;

		// Host writes; fill value and go come from the same word
		if (wr_ctrl) begin
			st_d.ctrl = wdata_i[`SMF_CTRL_W-1:0];
		end
		if (wr_mode) begin
			// Upper bits are not stored, so a stray one cannot disturb the block
			st_d.mode = wdata_i[`SMF_MODE_W-1:0];
		end
		if (wr_mask) begin
			st_d.mask = wdata_i[`SMF_IRQ_W-1:0];
		end

		// Fill sequence
		case (st_q.fstate)
			smf_pkg::SMF_FL_IDLE: begin
				if (go_rise & st_d.ctrl[`SMF_CTRL_ARM]) begin
					st_d.fstate = smf_pkg::SMF_FL_WRITE;
					st_d.faddr = `SMF_CM_ZERO;
					st_d.frames = `SMF_FRAMES_ZERO;
				end
			end
			smf_pkg::SMF_FL_WRITE: begin
				st_d.cm_we = 1'b1;
				st_d.cm_addr = st_q.faddr;
				st_d.cm_wdata = {st_q.mode[`SMF_MODE_VAL_HI:`SMF_MODE_VAL_LO],
					`SMF_CM_LOW_ZERO};
				st_d.faddr = st_q.faddr + 11'h001;
				if (st_q.faddr == `SMF_CM_LAST) begin
					st_d.fstate = smf_pkg::SMF_FL_WAIT;
				end
			end
			smf_pkg::SMF_FL_WAIT: begin
				if (fill_done) begin
					st_d.fstate = smf_pkg::SMF_FL_IDLE;
					// A host write in this cycle wins over the self clear
					if (!wr_mode) begin
						st_d.mode[`SMF_MODE_GO] = 1'b0;
					end
				end
			end
			default: begin
				st_d.fstate = smf_pkg::SMF_FL_IDLE;
			end
		endcase

		// Frame starts counted from go; writes take far less than a frame
		if ((st_q.fstate != smf_pkg::SMF_FL_IDLE) & frame_pulse_i &
			(st_q.frames != `SMF_FILL_FRAMES)) begin
			st_d.frames = st_q.frames + 2'h1;
		end

		// Abort from any active state, leaving memory partly filled
		if (abort & (st_q.fstate != smf_pkg::SMF_FL_IDLE)) begin
			st_d.fstate = smf_pkg::SMF_FL_IDLE;
			st_d.cm_we = 1'b0;
		end

		// Sticky status: a new event wins over a write-one clear
		if (wr_stat) begin
			st_d.stat = st_q.stat & ~wdata_i[`SMF_IRQ_W-1:0];
		end
		st_d.stat = st_d.stat | events;

		// Read data stands the cycle after the strobe; unmapped reads give zero
		if (rd_i) begin
			case (addr_i)
				`SMF_OFS_CTRL: begin
					st_d.rdata = {10'h000, st_q.ctrl};
				end
				`SMF_OFS_MODE: begin
					st_d.rdata = {6'h00, st_q.mode};
				end
				`SMF_OFS_RESULT: begin
					st_d.rdata = result_word;
				end
				`SMF_OFS_IRQ_STAT: begin
					st_d.rdata = {14'h0000, st_q.stat};
				end
				`SMF_OFS_IRQ_MASK: begin
					st_d.rdata = {14'h0000, st_q.mask};
				end
				default: begin
					st_d.rdata = `SMF_DATA_ZERO;
				end
			endcase
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= '0;
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end

	// Register outputs
	assign rdata_o = st_q.rdata;
	assign cm_we_o = st_q.cm_we & ce_i;
	assign cm_addr_o = st_q.cm_addr;
	assign cm_wdata_o = st_q.cm_wdata;
	assign stream_sel_o = st_q.ctrl[3:0];
	assign mem_select_o = st_q.ctrl[4];
	assign fill_busy_o = (st_q.fstate != smf_pkg::SMF_FL_IDLE);

	// Rate field passed to the serial timing; master clock is the user's duty
	assign rate_select_o = st_q.mode[`SMF_MODE_RATE_HI:`SMF_MODE_RATE_LO];
	assign rate_reserved_o = (rate_select_o == `SMF_RATE_RSVD);

	// All sixteen drivers float only when both pin and standby bit are low
	genvar gi;
	generate
		for (gi = 0; gi < `SMF_STREAMS; gi++) begin : g_oe
			assign serial_out_streams_oe_n_o[gi] =
				~(output_drive_pin_i | st_q.mode[`SMF_MODE_STBY]);
		end
	endgenerate

	// Level interrupt from unmasked sticky bits
	assign irq_o = |(st_q.stat & st_q.mask);

endmodule : smf_top

`default_nettype wire

/* sim/smf_top_properties.sv */
// Concurrent checks on the host port, fill engine, rate and output enables.
// Assumes ce_i stays high while the properties are meant to hold.
`timescale 1ns/1ps
`default_nettype none
`include "smf_defs.svh"

module smf_top_chk (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Host port
	input wire logic [`SMF_ADDR_W-1:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	// Pins, fill port and rate
	input wire logic output_drive_pin_i,
	input wire logic [`SMF_STREAMS-1:0] serial_out_streams_oe_n_o,
	input wire logic cm_we_o,
	input wire logic [`SMF_CM_AW-1:0] cm_addr_o,
	input wire logic [15:0] cm_wdata_o,
	input wire logic [1:0] rate_select_o,
	input wire logic rate_reserved_o,
	input wire logic fill_busy_o
);
	logic stby_q;
	logic mode_wr;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	assign mode_wr = wr_i && ce_i && addr_i == `SMF_OFS_MODE;
	// Shadow of the standby bit, safe because only the host ever changes it
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stby_q <= 1'b0;
		end else if (mode_wr) begin
			stby_q <= wdata_i[`SMF_MODE_STBY];
		end
	end
	a_oe_float: assert property (serial_out_streams_oe_n_o ==
		((output_drive_pin_i || stby_q) ? 16'h0000 : 16'hffff)) else $error("oe mismatch");
	a_rdata_quiet: assert property (!$past(rd_i && ce_i) |-> rdata_o == 16'h0000)
		else $error("read data outside slot");
	a_fill_launch: assert property ($rose(fill_busy_o) |-> $past(mode_wr && wdata_i[4]))
		else $error("fill without go write");
	a_fill_first: assert property ($rose(fill_busy_o) |=> cm_we_o && cm_addr_o == 11'h000)
		else $error("first fill write late");
	a_fill_word: assert property (cm_we_o |-> cm_wdata_o[10:0] == 11'h000)
		else $error("fill low bits not zero");
	a_fill_step: assert property (cm_we_o && $past(cm_we_o) |->
		cm_addr_o == $past(cm_addr_o) + 11'h001) else $error("fill address skipped");
	a_we_in_fill: assert property (cm_we_o |-> $past(fill_busy_o))
		else $error("write outside fill");
	a_rate_store: assert property (mode_wr |=> rate_select_o == $past(wdata_i[1:0]))
		else $error("rate not stored");
	a_rate_rsvd: assert property (rate_reserved_o == (rate_select_o == 2'h3))
		else $error("reserved flag wrong");
	c_fill: cover property ($rose(fill_busy_o));
	c_fill_end: cover property ($fell(fill_busy_o));
	c_result_rd: cover property (rd_i && addr_i == `SMF_OFS_RESULT);
endmodule : smf_top_chk

bind smf_top smf_top_chk dut_chk (.mclk_i, .nrst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .output_drive_pin_i, .serial_out_streams_oe_n_o, .cm_we_o, .cm_addr_o,
	.cm_wdata_o, .rate_select_o, .rate_reserved_o, .fill_busy_o);
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for smf_top: registers, standby, offset result, fill, irq.
// Assumes one clock; ce_i stays high; expectations come from bench code only.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic mclk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic ce_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0, rd_i = 1'b0, fp_i = 1'b0, fe_i = 1'b0, gci_i = 1'b0;
	logic hp_i = 1'b0, odp_i = 1'b0;
	logic [15:0] rdata_o, oe_n_o, cm_wdata_o, exp_cm, v;
	logic [10:0] cm_addr_o;
	logic [3:0] ssel_o;
	logic [1:0] rate_o;
	logic [4:0] fv;
	logic cm_we_o, msel_o, rrsvd_o, busy_o, irq_o;
	logic [31:0] seed = 32'h00000048;
	int n_fail = 0, n_tests = 0, n_we = 0, k, s, t;

	// Clock at 25 MHz
	always #20 mclk_i = ~mclk_i;

	smf_top dut_u (.mclk_i, .nrst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.frame_pulse_i(fp_i), .frame_eval_input_i(fe_i), .gci_mode_i(gci_i),
		.half_phase_i(hp_i), .output_drive_pin_i(odp_i), .serial_out_streams_oe_n_o(oe_n_o),
		.cm_we_o, .cm_addr_o, .cm_wdata_o, .stream_sel_o(ssel_o), .mem_select_o(msel_o),
		.rate_select_o(rate_o), .rate_reserved_o(rrsvd_o), .fill_busy_o(busy_o), .irq_o);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("fails=%0d tests=%0d", n_fail, n_tests);
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop

	// Bus tasks step off the edge first so back-to-back strobes never collide
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		#1;
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		#1;
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask : rdc

	task automatic frame();
		fp_i <= 1'b1;
		@(posedge mclk_i);
		fp_i <= 1'b0;
	endtask : frame

	// Every fill write is counted and its word checked away from the edge
	always @(negedge mclk_i) begin
		if (cm_we_o === 1'b1) begin
			n_we <= n_we + 1;
			chk(cm_wdata_o, exp_cm);
		end
	end

	initial begin
		repeat (16) @(posedge mclk_i);
		nrst_i <= 1'b1;
		@(posedge mclk_i);
		// Reset values, a write to the read-only result, an unmapped read
		wr(8'h02, 16'hffff);
		rdc(8'h00, 16'h0000);
		rdc(8'h01, 16'h0000);
		rdc(8'h02, 16'h0000);
		rdc(8'h08, 16'h0000);
		rdc(8'h09, 16'h0000);
		rdc(8'h05, 16'h0000);
		// Random register values through all rate codes and standby cases
		for (int i = 0; i < 8; i++) begin
			v = rnd();
			// Upper unused bits are written as zeros, as software must
			wr(8'h00, {11'h000, v[4:0]});
			wr(8'h01, {6'h00, v[9:5], 1'b0, v[3], 1'b0, i[1:0]});
			rdc(8'h00, {11'h000, v[4:0]});
			rdc(8'h01, {6'h00, v[9:5], 1'b0, v[3], 1'b0, i[1:0]});
			chk({11'h000, msel_o, ssel_o}, {11'h000, v[4:0]});
			chk({13'h0000, rrsvd_o, rate_o}, {13'h0000, i[1:0] == 2'h3, i[1:0]});
			odp_i <= v[10];
			@(posedge mclk_i);
			#1 chk(oe_n_o, (v[10] || v[3]) ? 16'h0000 : 16'hffff);
		end
		// Offset measurement on both edge polarities, eval interrupt unmasked
		wr(8'h09, 16'h0002);
		for (int g = 0; g < 2; g++) begin
			k = 2 + (rnd() & 31);
			gci_i <= g[0];
			fe_i <= ~g[0];
			hp_i <= k[0];
			wr(8'h01, 16'h0004);
			repeat (3) @(posedge mclk_i);
			frame();
			repeat (k - 1) @(posedge mclk_i);
			fe_i <= g[0];
			repeat (4) @(posedge mclk_i);
			rdc(8'h02, {3'h0, 1'b1, k[0], k[10:0] - 11'h001});
			chk({15'h0000, irq_o}, 16'h0001);
			wr(8'h08, 16'h0002);
			#1 chk({15'h0000, irq_o}, 16'h0000);
			wr(8'h01, 16'h0000);
			// The measurement sees the falling start bit one cycle after the write
			@(posedge mclk_i);
			rdc(8'h02, 16'h0000);
			frame();
		end
		// Full fill; frames come late so completion must wait for the second one
		fv = rnd();
		exp_cm = {fv, 11'h000};
		wr(8'h00, 16'h0020);
		s = n_we;
		wr(8'h01, {6'h00, fv, 5'h10});
		t = 0;
		for (int i = 0; i < 4000; i++) begin
			@(posedge mclk_i);
			#1 fp_i <= (i % 1500 == 1499);
			if (i > 2 && busy_o === 1'b0 && t == 0) begin
				t = i;
			end
		end
		if (t == 0) begin
			n_fail++;
			report_and_stop();
		end
		chk({15'h0000, t >= 2999}, 16'h0001);
		chk(16'(n_we - s), 16'd2048);
		rdc(8'h01, {6'h00, fv, 5'h00});
		rdc(8'h08, 16'h0001);
		chk({15'h0000, irq_o}, 16'h0000);
		wr(8'h09, 16'h0003);
		#1 chk({15'h0000, irq_o}, 16'h0001);
		wr(8'h08, 16'h0001);
		#1 chk({15'h0000, irq_o}, 16'h0000);
		// Abort by go, abort by arm, then a go without arm is refused
		exp_cm = 16'h0000;
		wr(8'h01, 16'h0010);
		repeat (100) @(posedge mclk_i);
		wr(8'h01, 16'h0000);
		s = n_we;
		repeat (4) @(posedge mclk_i);
		#1 chk({15'h0000, busy_o}, 16'h0000);
		chk(16'(n_we - s), 16'h0000);
		wr(8'h01, 16'h0010);
		repeat (50) @(posedge mclk_i);
		wr(8'h00, 16'h0000);
		repeat (20) @(posedge mclk_i);
		#1 chk({15'h0000, busy_o}, 16'h0000);
		rdc(8'h08, 16'h0000);
		wr(8'h01, 16'h0000);
		s = n_we;
		wr(8'h01, 16'h0010);
		repeat (4) @(posedge mclk_i);
		#1 chk({15'h0000, busy_o}, 16'h0000);
		chk(16'(n_we - s), 16'h0000);
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
